// *** core/lc_consts.svh ***
// Purpose: offsets, field positions and reset values of the cluster
// Assumes: included by its bare name
// Notes: byte addresses on the register bus
`ifndef LC_CONSTS_SVH
`define LC_CONSTS_SVH

`define LC_NCELLS 16
`define LC_POOL_W 64
`define LC_SEL_W 6

// per-cell words sit below the status word, 8 bytes per cell
`define LC_STATUS_OFS 12'h080
`define LC_CTRL_OFS 12'h084
`define LC_CFG_RST 32'h0000_0000
`define LC_CTRL_RST 1'b0

// config word a
`define LC_LUT_MSB 15
`define LC_KIND_LSB 16
`define LC_KIND_MSB 17
`define LC_ARITH_BIT 18
`define LC_CINSEL_BIT 19
`define LC_FBK_BIT 20
`define LC_PACK_BIT 21
`define LC_CHAIN_BIT 22
`define LC_CLKSEL_BIT 23
`define LC_ACLR1_BIT 24
`define LC_ACLR2_BIT 25
`define LC_SLOAD_BIT 26
`define LC_SCLR_BIT 27
`define LC_ORC_BIT 28
`define LC_OLNK_BIT 29
`define LC_OLOC_BIT 30

// config word b: four source selects into the local pool
`define LC_SELA_LSB 0
`define LC_SELB_LSB 6
`define LC_SELC_LSB 12
`define LC_SELD_LSB 18

// control word
`define LC_DEVCLR_EN_BIT 0

`endif

// *** core/lc_pkg.sv ***
// Purpose: types shared by the logic cluster
// Assumes: constants come from lc_consts.svh
// Notes: none
package lc_pkg;

   typedef enum logic [1:0] {
      FF_D,
      FF_T,
      FF_JK,
      FF_SR
   } ff_kind_e;

   typedef struct packed {
      logic cluster_clock_one;
      logic cluster_clock_two;
      logic cluster_clock_enable_one;
      logic cluster_clock_enable_two;
      logic cluster_async_clear_one;
      logic cluster_async_clear_two;
      logic cluster_sync_clear;
      logic cluster_sync_load;
   } cluster_ctrl_s;

endpackage : lc_pkg

// *** core/logic_cluster.sv ***
// Purpose: one logic cluster of sixteen logic cells, configured over AHB-Lite
// Assumes: all cell storage runs on hclk; cluster clocks are sampled
// Notes: cluster clocks, clears and loads are pins, so they are synchronised
//
// Notes on behaviour
// - each cell register acts as a D, T, JK or SR flip-flop
// - every register has data, clock, clock enable and clear inputs
// - each cell has a four-input table computing any function
// - combinational functions bypass the register to the cell outputs
// - three outputs, each picks table result or register independently
// - packed register takes separate data and ignores synchronous load
// - register may feed own table; registered and unregistered out
// - register chain feeds next cell register inside the cluster
// - carry chain links cells; cluster carry in and out extend it
// - six cell inputs: four data, carry in, register chain in
// - clock, clear, load and enable reach every cell in both modes
// - normal mode table; one input is carry in or fourth data
// - normal mode supports packing and register feedback
// - arithmetic mode makes a 1-bit full adder with carry out
// - arithmetic mode keeps feedback, packing and dual outputs
// - exactly 16 cells with controls, chains and local routing
// - local routing fed by row, column, own cells and neighbours
// - each cell output reaches up to 48 cells locally and by links
// - clock and clear from any source, enable only pins or logic
// - carry chain continues vertically through clusters in a column
// - two clocks, two enables, two clears, one sclr, one sload
// - each clock paired with an enable that stops it
// - optional device-wide clear resets all registers, top priority
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "lc_consts.svh"

module logic_cluster (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire lc_pkg::cluster_ctrl_s cluster_ctrl,
   input wire logic device_wide_clear_n,
   input wire logic [15:0] row_col_in,
   input wire logic [15:0] left_link_in,
   input wire logic [15:0] right_link_in,
   input wire logic carry_in,
   input wire logic reg_chain_in,
   output logic [15:0] row_col_out,
   output logic [15:0] link_out,
   output logic [15:0] local_out,
   output logic carry_out,
   output logic reg_chain_out
);

   function automatic logic lut4(
      input logic [15:0] mask,
      input logic [3:0] idx
   );
      return mask[idx];
   endfunction : lut4

   function automatic logic cell_hit(
      input logic [11:0] a,
      input logic [3:0] idx,
      input logic wb
   );
      return (a < `LC_STATUS_OFS) && (a[6:3] == idx) && (a[2] == wb)
         && (a[1:0] == 2'h0);
   endfunction : cell_hit

   logic [31:0] cfg_a_ff [`LC_NCELLS];
   logic [31:0] cfg_b_ff [`LC_NCELLS];
   logic devclr_en_ff;
   logic [15:0] q_ff;

   // bus slave
   logic [11:0] addr_ff;
   logic wr_ff;
   logic rd_ff;
   logic [31:0] hrdata_ff;
   logic [31:0] rd_mux;
   logic accept;

   assign accept = hsel & htrans[1] & hready;
   // reads take one wait state so read data comes from a flop
   assign hreadyout = ~rd_ff;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_ff <= 12'h000;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
      end else if (hready) begin
         wr_ff <= accept & hwrite;
         rd_ff <= accept & ~hwrite;
         if (accept) begin
            addr_ff <= haddr[11:0];
         end
      end else begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr_ff == `LC_STATUS_OFS) begin
         rd_mux = {16'h0000, q_ff};
      end else if (addr_ff == `LC_CTRL_OFS) begin
         rd_mux = {31'h0000_0000, devclr_en_ff};
      end else if ((addr_ff < `LC_STATUS_OFS) && (addr_ff[1:0] == 2'h0)) begin
         rd_mux = addr_ff[2] ? cfg_b_ff[addr_ff[6:3]] : cfg_a_ff[addr_ff[6:3]];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_ff) begin
         hrdata_ff <= rd_mux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         devclr_en_ff <= `LC_CTRL_RST;
      end else if (wr_ff && hready && (addr_ff == `LC_CTRL_OFS)) begin
         devclr_en_ff <= hwdata[`LC_DEVCLR_EN_BIT];
      end
   end

   // control synchronisers; stage three only serves edge detection
   logic [7:0] ctl_s1_ff;
   logic [7:0] ctl_s2_ff;
   logic [7:0] ctl_s3_ff;
   logic devclr_s1_ff;
   logic devclr_s2_ff;
   lc_pkg::cluster_ctrl_s ctl;
   lc_pkg::cluster_ctrl_s ctl_old;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_s1_ff <= 8'h00;
         ctl_s2_ff <= 8'h00;
         ctl_s3_ff <= 8'h00;
      end else begin
         ctl_s1_ff <= cluster_ctrl;
         ctl_s2_ff <= ctl_s1_ff;
         ctl_s3_ff <= ctl_s2_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         devclr_s1_ff <= 1'b1;
         devclr_s2_ff <= 1'b1;
      end else begin
         devclr_s1_ff <= device_wide_clear_n;
         devclr_s2_ff <= devclr_s1_ff;
      end
   end

   assign ctl = lc_pkg::cluster_ctrl_s'(ctl_s2_ff);
   assign ctl_old = lc_pkg::cluster_ctrl_s'(ctl_s3_ff);

   // the full set of six cluster controls plus two clocks
   // an enable low swallows the whole clock edge, not just a cell
   logic edge_one;
   logic edge_two;
   logic devclr_act;

   assign edge_one = ctl.cluster_clock_one & ~ctl_old.cluster_clock_one
      & ctl.cluster_clock_enable_one;
   assign edge_two = ctl.cluster_clock_two & ~ctl_old.cluster_clock_two
      & ctl.cluster_clock_enable_two;
   // clock and clear may be driven by any source that reaches the pins;
   // enable is only ever a pin or logic level, never a clock net
   assign devclr_act = devclr_en_ff & ~devclr_s2_ff;

   // local interconnect pool
   // own cells enter registered, so routing can never form a comb loop
   logic [`LC_POOL_W-1:0] pool;
   assign pool = {right_link_in, left_link_in, row_col_in, q_ff};

   logic [16:0] cy;
   logic [16:0] rc;
   assign cy[0] = carry_in;
   assign carry_out = cy[16];
   assign rc = {q_ff, reg_chain_in};
   assign reg_chain_out = q_ff[15];

   // sixteen identical cells
   for (genvar i = 0; i < `LC_NCELLS; i++) begin : g_cell
      logic [31:0] ca;
      logic [31:0] cb;
      logic da;
      logic db;
      logic dc;
      logic dd;
      logic in_a;
      logic in_d;
      logic lut_o;
      logic co;
      logic dsrc;
      logic aclr;
      logic ev;
      logic nxt_q;

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cfg_a_ff[i] <= `LC_CFG_RST;
         end else if (wr_ff && hready && cell_hit(addr_ff, 4'(i), 1'b0)) begin
            cfg_a_ff[i] <= hwdata;
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cfg_b_ff[i] <= `LC_CFG_RST;
         end else if (wr_ff && hready && cell_hit(addr_ff, 4'(i), 1'b1)) begin
            cfg_b_ff[i] <= hwdata;
         end
      end

      assign ca = cfg_a_ff[i];
      assign cb = cfg_b_ff[i];

      // four data inputs from local routing, plus carry and chain
      assign da = pool[cb[`LC_SELA_LSB +: `LC_SEL_W]];
      assign db = pool[cb[`LC_SELB_LSB +: `LC_SEL_W]];
      assign dc = pool[cb[`LC_SELC_LSB +: `LC_SEL_W]];
      assign dd = pool[cb[`LC_SELD_LSB +: `LC_SEL_W]];

      // register feedback into own table
      assign in_a = ca[`LC_FBK_BIT] ? q_ff[i] : da;
      assign in_d = ca[`LC_CINSEL_BIT] ? cy[i] : dd;

      // arithmetic: low half of the mask is the sum, high half the carry
      // carry leaves through its own net so cy has continuous drivers only
      always_comb begin
         if (ca[`LC_ARITH_BIT]) begin
            lut_o = lut4(ca[`LC_LUT_MSB:0], {1'b0, cy[i], db, in_a});
            co = lut4(ca[`LC_LUT_MSB:0], {1'b1, cy[i], db, in_a});
         end else begin
            lut_o = lut4(ca[`LC_LUT_MSB:0], {in_d, dc, db, in_a});
            co = cy[i];
         end
      end

      assign cy[i+1] = co;

      // packed: register takes fourth input, unrelated to the table
      always_comb begin
         if (ca[`LC_CHAIN_BIT]) begin
            dsrc = rc[i];
         end else if (ca[`LC_PACK_BIT]) begin
            dsrc = dd;
         end else begin
            dsrc = lut_o;
         end
      end

      always_comb begin
         case (lc_pkg::ff_kind_e'(ca[`LC_KIND_MSB:`LC_KIND_LSB]))
            lc_pkg::FF_D: begin
               nxt_q = dsrc;
            end
            lc_pkg::FF_T: begin
               nxt_q = q_ff[i] ^ dsrc;
            end
            lc_pkg::FF_JK: begin
               nxt_q = (dsrc & ~q_ff[i]) | (~dc & q_ff[i]);
            end
            lc_pkg::FF_SR: begin
               nxt_q = dsrc | (~dc & q_ff[i]);
            end
            default: begin
               nxt_q = q_ff[i];
            end
         endcase
      end

      // clock select and per-cell clear select
      assign ev = ca[`LC_CLKSEL_BIT] ? edge_two : edge_one;
      assign aclr = (ca[`LC_ACLR1_BIT] & ctl.cluster_async_clear_one)
         | (ca[`LC_ACLR2_BIT] & ctl.cluster_async_clear_two);

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            q_ff[i] <= 1'b0;
         end else if (devclr_act) begin
            q_ff[i] <= 1'b0;
         end else if (aclr) begin
            q_ff[i] <= 1'b0;
         end else if (ev) begin
            if (ca[`LC_SCLR_BIT] && ctl.cluster_sync_clear) begin
               q_ff[i] <= 1'b0;
            end else if (ca[`LC_SLOAD_BIT] && !ca[`LC_PACK_BIT]
               && ctl.cluster_sync_load) begin
               q_ff[i] <= dd;
            end else begin
               q_ff[i] <= nxt_q;
            end
         end
      end

      // each output picks table or register; table path is a bypass
      assign row_col_out[i] = ca[`LC_ORC_BIT] ? q_ff[i] : lut_o;
      // link_out drives both neighbours' pools: 16 + 16 cells
      assign link_out[i] = ca[`LC_OLNK_BIT] ? q_ff[i] : lut_o;
      assign local_out[i] = ca[`LC_OLOC_BIT] ? q_ff[i] : lut_o;
   end

endmodule : logic_cluster

// *** verif/logic_cluster_properties.sv ***
// Purpose: bus timing and register hold checks on the cluster ports
// Assumes: hready is tied to hreadyout
// Notes: cell configuration is not visible here, so cell checks stay generic
`timescale 1ns/1ps
module logic_cluster_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire lc_pkg::cluster_ctrl_s cluster_ctrl,
   input wire logic device_wide_clear_n,
   input wire logic reg_chain_out
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [2:0] quiet_ff;
   wire logic taken = hsel && htrans[1] && hready;
   // counts cycles with no control pin movement and no device clear; saturates
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         quiet_ff <= 3'h0;
      end else if (!$stable(cluster_ctrl) || !device_wide_clear_n) begin
         quiet_ff <= 3'h0;
      end else if (quiet_ff != 3'h7) begin
         quiet_ff <= quiet_ff + 3'h1;
      end
   end
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (taken && hwrite |=> hreadyout)
      else $error("write stalled");
   a_wait_single: assert property (!hreadyout |=> hreadyout)
      else $error("wait longer than one cycle");
   a_wait_cause: assert property ($fell(hreadyout) |-> $past(taken && !hwrite))
      else $error("wait without a read");
   a_rdata_hold: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
      else $error("read data moved outside a read");
   a_reset_zero: assert property ($rose(hresetn) |-> hrdata == 32'h0 && !reg_chain_out)
      else $error("state not cleared by reset");
   a_chain_quiet: assert property (quiet_ff == 3'h7 |-> $stable(reg_chain_out))
      else $error("register moved without a clock event");
endmodule : logic_cluster_properties

// *** verif/fabric_model.sv ***
// Purpose: fabric side that pulses cluster clock one or cluster clock two
// Assumes: one pulse for each go request
// Notes: high held 3 hclk periods, low at least 4, above the 2 the cluster needs
`timescale 1ns/1ps
module fabric_model (
   input wire logic hclk,
   input wire logic go,
   output logic clock_one,
   output logic busy
);
   logic [2:0] cnt_ff = 3'h0;
   always_ff @(posedge hclk) begin
      if (go && cnt_ff == 3'h0) begin
         cnt_ff <= 3'h6;
      end else if (cnt_ff != 3'h0) begin
         cnt_ff <= cnt_ff - 3'h1;
      end
   end
   // clock stands low between pulses
   assign clock_one = cnt_ff > 3'h3;
   assign busy = go || cnt_ff != 3'h0;
endmodule : fabric_model

// *** verif/logic_cluster_tb.sv ***
// Purpose: self-checking bench for the logic cluster
// Assumes: cluster clock pulses come from fabric_model
// Notes: driver queues expectations, the monitor checks them
`timescale 1ns/1ps
`include "lc_consts.svh"
module logic_cluster_tb;
   typedef struct packed {
      logic pin;
      logic [31:0] msk;
      logic [31:0] val;
   } note_s;
   note_s notes[$];
   logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, go = 1'b0;
   logic busy, clock_one, carry_out, reg_chain_out, look = 1'b0, rd_ph = 1'b0;
   logic en1 = 1'b1, aclr1 = 1'b0, sclr = 1'b0, sload = 1'b0, device_wide_clear_n = 1'b1;
   logic carry_in = 1'b0, reg_chain_in = 1'b0;
   logic clock_two, busy2, en2 = 1'b1, aclr2 = 1'b0, go2 = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [15:0] row_col_in = 16'h0, left_link_in = 16'h0, right_link_in = 16'h0;
   logic [15:0] row_col_out, link_out, local_out, rnd = 16'h80b4;
   logic [4:0] pins;
   int n_fail = 0, cmp_count = 0;
   assign pins = {reg_chain_out, carry_out, local_out[0], link_out[0], row_col_out[0]};
   fabric_model i_fab (.hclk(hclk), .go(go), .clock_one(clock_one), .busy(busy));
   fabric_model i_fab2 (.hclk(hclk), .go(go2), .clock_one(clock_two), .busy(busy2));
   logic_cluster i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .cluster_ctrl({clock_one, clock_two, en1, en2, aclr1, aclr2, sclr, sload}),
      .device_wide_clear_n(device_wide_clear_n), .row_col_in(row_col_in),
      .left_link_in(left_link_in), .right_link_in(right_link_in), .carry_in(carry_in),
      .reg_chain_in(reg_chain_in), .row_col_out(row_col_out), .link_out(link_out),
      .local_out(local_out), .carry_out(carry_out), .reg_chain_out(reg_chain_out));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic end_sim;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= wr;
      @(negedge hclk);
      while (!hreadyout) @(negedge hclk);
      @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(negedge hclk);
      while (!hreadyout) @(negedge hclk);
      @(posedge hclk);
   endtask : bus
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      notes.push_back({1'b0, 32'hffff_ffff, e});
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic chk(input logic [4:0] m, input logic [4:0] e);
      @(posedge hclk);
      notes.push_back({1'b1, 27'h0, m, 27'h0, e});
      look <= 1'b1;
      @(posedge hclk);
      look <= 1'b0;
   endtask : chk
   task automatic ev(input logic two = 1'b0);
      go <= !two;
      go2 <= two;
      @(posedge hclk);
      go <= 1'b0;
      go2 <= 1'b0;
      @(negedge hclk);
      while (busy || busy2) @(negedge hclk);
      @(posedge hclk);
   endtask : ev
   task automatic cmp_rd;
      note_s n;
      n = notes.pop_front();
      cmp_count++;
      if (hrdata !== n.val) begin
         n_fail++;
         $display("Error %0t read %h expected %h", $time, hrdata, n.val);
      end
   endtask : cmp_rd
   task automatic cmp_pin;
      note_s n;
      n = notes.pop_front();
      cmp_count++;
      if ((pins & n.msk[4:0]) !== n.val[4:0]) begin
         n_fail++;
         $display("Error %0t pins %b expected %b", $time, pins, n.val[4:0]);
      end
   endtask : cmp_pin
   always @(posedge hclk) begin
      if (rd_ph && hreadyout) cmp_rd();
      if (look) cmp_pin();
      if (hsel && htrans[1] && hreadyout) rd_ph = !hwrite;
      else if (hreadyout) rd_ph = 1'b0;
   end
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end
   initial begin
      logic [31:0] m;
      logic [19:0] bits;
      logic e2;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd(12'h000, `LC_CFG_RST);
      rd(`LC_CTRL_OFS, 32'h0);
      bus(1'b1, 12'h100, 32'hffff_ffff);
      rd(12'h100, 32'h0);
      // inputs a..d taken from row_col_in[3:0]
      bus(1'b1, 12'h004, {8'h0, 6'h13, 6'h12, 6'h11, 6'h10});
      for (int ar = 0; ar < 2; ar++) begin
         rnd = lfsr(rnd);
         m = {13'h0, ar[0], 2'h0, rnd};
         bus(1'b1, 12'h000, m);
         rd(12'h000, m);
         for (int k = 0; k < 32; k++) begin
            rnd = lfsr(rnd);
            row_col_in <= {rnd[15:4], k[3:0]};
            left_link_in <= rnd;
            right_link_in <= ~rnd;
            carry_in <= k[4];
            if (ar == 0) chk(5'h0f, {1'b0, k[4], {3{m[k[3:0]]}}});
            else chk(5'h0f, {1'b0, m[{1'b1, k[4], k[1:0]}], {3{m[{1'b0, k[4], k[1:0]}]}}});
         end
      end
      // c and d high: packed data is d, k and r are c
      row_col_in <= 16'h000c;
      for (int kd = 0; kd < 4; kd++) begin
         bus(1'b1, 12'h000, 32'h1d20_ffff | {14'h0, kd[1:0], 16'h0});
         sclr <= 1'b1;
         sload <= 1'b1;
         ev();
         chk(5'h05, 5'h04);
         sclr <= 1'b0;
         ev();
         chk(5'h05, 5'h05);
         ev();
         e2 = !(kd == 1 || kd == 2);
         chk(5'h05, 5'h04 | {4'h0, e2});
         en1 <= 1'b0;
         ev();
         chk(5'h05, 5'h04 | {4'h0, e2});
         aclr1 <= 1'b1;
         repeat (4) @(posedge hclk);
         chk(5'h05, 5'h04);
         aclr1 <= 1'b0;
         en1 <= 1'b1;
      end
      sload <= 1'b0;
      ev();
      chk(5'h05, 5'h05);
      bus(1'b1, `LC_CTRL_OFS, 32'h1);
      device_wide_clear_n <= 1'b0;
      repeat (4) @(posedge hclk);
      chk(5'h05, 5'h04);
      device_wide_clear_n <= 1'b1;
      for (int i = 0; i < 16; i++) bus(1'b1, 12'(8 * i), 32'h1040_0000);
      for (int n = 0; n < 20; n++) begin
         rnd = lfsr(rnd);
         bits[n] = rnd[0];
         reg_chain_in <= rnd[0];
         ev();
         if (n >= 15) chk(5'h10, {bits[n - 15], 4'h0});
      end
      m = 32'h0;
      for (int i = 0; i < 16; i++) m[i] = bits[19 - i];
      rd(`LC_STATUS_OFS, m);
      // cell 0 on clock two: table is own register xor carry in, sync load used
      bus(1'b1, 12'h000, 32'h1698_55aa);
      aclr2 <= 1'b1;
      carry_in <= 1'b1;
      repeat (4) @(posedge hclk);
      chk(5'h03, 5'h02);
      aclr2 <= 1'b0;
      carry_in <= 1'b0;
      chk(5'h03, 5'h00);
      ev(1'b0);
      chk(5'h03, 5'h00);
      sload <= 1'b1;
      ev(1'b1);
      chk(5'h03, 5'h03);
      sload <= 1'b0;
      carry_in <= 1'b1;
      ev(1'b1);
      chk(5'h03, 5'h02);
      en2 <= 1'b0;
      ev(1'b1);
      chk(5'h03, 5'h02);
      end_sim();
   end
endmodule : logic_cluster_tb
bind logic_cluster logic_cluster_properties i_props (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .hrdata, .cluster_ctrl, .device_wide_clear_n,
   .reg_chain_out);
